/* File: tb/radio_spi_host.sv */
`timescale 1ns/1ns
module radio_spi_host (
  input  wire logic clock,
  output logic     chip_select_low,
  output logic     serial_clock,
  output logic     serial_in,
  input  wire logic serial_out
);
  initial
  begin
    chip_select_low = 1'b1;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end
  // serial clock rests low between frames
  task automatic select();
    int n;
    n = 0;
    // pin edges kept off the sampling clock edge
    @(posedge clock);
    #3;
    chip_select_low = 1'b0;
    while (serial_out !== 1'b0 && n < 400)
    begin
      #10;
      n++;
    end
  endtask
  task automatic xfer(input logic [7:0] tx, input int nb,
                      output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clock);
    #3;
    for (int i = 7; i > 7 - nb; i--)
    begin
      serial_in = tx[i];
      #40 serial_clock = 1'b1;
      #38 rx[i] = serial_out;
      #2 serial_clock = 1'b0;
    end
  endtask
  task automatic deselect();
    #40 chip_select_low = 1'b1;
    serial_in = ~serial_in;
    #200;
  endtask
endmodule // radio_spi_host

/* File: tb/tb_radio_spi_port.sv */
`timescale 1ns/1ns
module tb_radio_spi_port;
  import radio_spi_pkg::*;
  logic         clock, resetn, crystal_stable, rx_overflow, tx_underflow;
  logic [6:0]   rx_fill, tx_free;
  logic         cs_n, sck, sdi, sdo, oe_n, strobe_pulse;
  logic [3:0]   strobe_code;
  radio_state_t radio_state;
  logic [7:0]   r;
  int           fails, n_compared, n_pulse, cyc;

  radio_spi_host host (.clock(clock), .chip_select_low(cs_n), .serial_clock(sck),
    .serial_in(sdi), .serial_out(sdo));
  radio_spi_port #(.SETTLE(100)) DUT (.clock(clock), .resetn(resetn),
    .chip_select_low(cs_n), .serial_clock(sck), .serial_in(sdi),
    .serial_out(sdo), .serial_out_enable_low(oe_n),
    .crystal_stable(crystal_stable), .rx_overflow(rx_overflow),
    .tx_underflow(tx_underflow), .rx_fill(rx_fill), .tx_free(tx_free),
    .radio_state(radio_state), .strobe_code(strobe_code),
    .strobe_pulse(strobe_pulse));

  initial clock = 1'b0;
  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    if (strobe_pulse === 1'b1)
      n_pulse <= n_pulse + 1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic t_ready();
    host.select();
    chk("not ready", {7'h00, sdo}, 8'h01);
    @(posedge clock);
    crystal_stable <= 1'b1;
    host.select();
    chk("ready", {7'h00, sdo}, 8'h00);
    chk("drive", {7'h00, oe_n}, 8'h00);
    host.deselect();
    chk("release", {7'h00, oe_n}, 8'h01);
    chk("idle out", {7'h00, sdo}, 8'h01);
  endtask
  task automatic t_burst();
    host.select();
    host.xfer(8'h6D, 8, r);
    chk("wr hdr", r, 8'h0F);
    host.xfer(8'h25, 8, r);
    chk("wr d0", r, 8'h0F);
    host.xfer(8'h5A, 8, r);
    chk("wr d1", r, 8'h0F);
    host.deselect();
    host.select();
    host.xfer(8'hED, 8, r);
    chk("rd hdr", r, 8'h05);
    host.xfer(8'h00, 8, r);
    chk("rd 2d", r, 8'h25);
    host.xfer(8'h00, 8, r);
    chk("rd 2e", r, 8'h5A);
    host.deselect();
  endtask
  task automatic t_strobe();
    host.select();
    host.xfer(8'h34, 8, r);
    chk("rx strobe", r, 8'h0F);
    chk("rx code", {4'h0, strobe_code}, 8'h04);
    host.xfer(8'hB4, 8, r);
    chk("rx status", r, 8'h15);
    host.xfer(8'h30, 8, r);
    chk("reset status", r, 8'h1F);
    host.select();
    chk("reset code", {4'h0, strobe_code}, 8'h00);
    host.deselect();
  endtask
  task automatic t_discard();
    int p0;
    p0 = n_pulse;
    host.select();
    host.xfer(8'h36, 8, r);
    chk("idle strobe", r, 8'h1F);
    host.xfer(8'h34, 8, r);
    chk("settling", r, 8'h5F);
    host.deselect();
    chk("pulses", 8'(n_pulse - p0), 8'h01);
    chk("idle code", {4'h0, strobe_code}, 8'h06);
    repeat (100) @(posedge clock);
    chk("idle", {5'h00, radio_state}, 8'h00);
  endtask
  task automatic t_flow(input logic [7:0] go, input logic uf,
                        input logic [7:0] fl, st, input logic [3:0] c);
    host.select();
    host.xfer(go, 8, r);
    @(posedge clock);
    rx_overflow <= !uf;
    tx_underflow <= uf;
    repeat (4) @(posedge clock);
    host.xfer(fl, 8, r);
    chk("flow status", r, st);
    chk("flush code", {4'h0, strobe_code}, {4'h0, c});
    rx_overflow <= 1'b0;
    tx_underflow <= 1'b0;
    host.xfer(8'h36, 8, r);
    host.deselect();
    repeat (110) @(posedge clock);
  endtask
  task automatic t_abandon();
    host.select();
    host.xfer(8'h05, 8, r);
    host.xfer(8'hC3, 8, r);
    host.xfer(8'h05, 8, r);
    host.xfer(8'hFF, 4, r);
    host.deselect();
    host.select();
    host.xfer(8'h85, 8, r);
    host.xfer(8'h00, 8, r);
    chk("abandoned", r, 8'hC3);
    host.deselect();
  endtask
  task automatic t_defer();
    logic [7:0] s [3] = '{8'h39, 8'h38, 8'h32};
    int p0;
    foreach (s[i])
    begin
      p0 = n_pulse;
      host.select();
      host.xfer(s[i], 8, r);
      chk("held", 8'(n_pulse - p0), 8'h00);
      host.deselect();
      chk("on cs", 8'(n_pulse - p0), 8'h01);
      chk("code", {4'h0, strobe_code}, s[i] - 8'h30);
    end
  endtask

  initial
  begin
    resetn <= 1'b0;
    crystal_stable <= 1'b0;
    rx_overflow <= 1'b0;
    tx_underflow <= 1'b0;
    rx_fill <= 7'h05;
    tx_free <= 7'h14;
    fails = 0;
    n_compared = 0;
    n_pulse = 0;
    cyc = 0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    t_ready();
    t_burst();
    t_strobe();
    t_discard();
    t_flow(8'h34, 1'b0, 8'hBA, 8'h65, 4'hA);
    t_flow(8'h35, 1'b1, 8'h3B, 8'h7F, 4'hB);
    t_abandon();
    t_defer();
    end_sim();
  end
endmodule // tb_radio_spi_port

/* File: verilog/radio_spi_params.svh */
`ifndef RADIO_SPI_PARAMS_SVH
`define RADIO_SPI_PARAMS_SVH
`define CFG_LAST_ADDR   6'h2E
`define STROBE_FIRST    6'h30
`define STROBE_LAST     6'h3D
`define STAT_RDY_BIT    7
`define STAT_STATE_MSB  6
`define STAT_STATE_LSB  4
`define LEVEL_MAX       4'hF
`define CFG_COUNT       47
`define STROBE_COUNT    13
`define CFG_RESET_VALUE 8'h00
`define ADDR_RADIO_STATE 6'h35
`define ADDR_TX_COUNT    6'h3A
`define ADDR_RX_COUNT    6'h3B
`define STROBE_SOFT_RESET 6'h30
`define STROBE_OSC_OFF    6'h32
`define STROBE_RX         6'h34
`define STROBE_TX         6'h35
`define STROBE_IDLE       6'h36
`define STROBE_WAKE_RADIO 6'h38
`define STROBE_POWER_DOWN 6'h39
`define STROBE_FLUSH_RX   6'h3A
`define STROBE_FLUSH_TX   6'h3B
`define SETTLE_NS         200
`define SETTLE_CYCLES     ((`SETTLE_NS + 9) / 10)
`endif

/* File: verilog/radio_spi_pkg.sv */
package radio_spi_pkg;
  typedef enum logic [2:0] {
    st_idle      = 3'b000,
    st_rx        = 3'b001,
    st_tx        = 3'b010,
    st_fast_tx   = 3'b011,
    st_calibrate = 3'b100,
    st_settling  = 3'b101,
    st_rx_over   = 3'b110,
    st_tx_under  = 3'b111
  } radio_state_t;

  typedef struct packed {
    logic       not_ready;
    logic [2:0] state;
    logic [3:0] level;
  } status_t;

  typedef struct packed {
    logic       read;
    logic       burst;
    logic [5:0] addr;
  } header_t;

  typedef enum logic [1:0] {
    ph_header = 2'b00,
    ph_write  = 2'b01,
    ph_read   = 2'b10,
    ph_skip   = 2'b11
  } phase_t;
endpackage

/* File: verilog/radio_spi_port.sv */
`timescale 1ns/1ns
`include "radio_spi_params.svh"
module radio_spi_port
  import radio_spi_pkg::*;
#(
  parameter int SETTLE = `SETTLE_CYCLES
)(
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic                chip_select_low,
  input  wire logic                serial_clock,
  input  wire logic                serial_in,
  output logic                     serial_out,
  output logic                     serial_out_enable_low,
  input  wire logic                crystal_stable,
  input  wire logic                rx_overflow,
  input  wire logic                tx_underflow,
  input  wire logic [6:0]          rx_fill,
  input  wire logic [6:0]          tx_free,
  output radio_spi_pkg::radio_state_t radio_state,
  output logic [3:0]               strobe_code,
  output logic                     strobe_pulse
);
  import radio_spi_pkg::*;

  logic [2:0] sync_cs, sync_sck, sync_si;
  logic [2:0] sync_xtal;
  logic       cs_low, sck_rise, sck_fall, cs_rise;
  logic       xtal_ok;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sync_cs   <= 3'h7;
      sync_sck  <= 3'h0;
      sync_si   <= 3'h0;
      sync_xtal <= 3'h0;
    end
    else
    begin
      sync_cs   <= {sync_cs[1:0], chip_select_low};
      sync_sck  <= {sync_sck[1:0], serial_clock};
      sync_si   <= {sync_si[1:0], serial_in};
      sync_xtal <= {sync_xtal[1:0], crystal_stable};
    end
  end
  assign cs_low   = !sync_cs[1];
  assign cs_rise  = sync_cs[1] && !sync_cs[2];
  assign sck_rise = cs_low && sync_sck[1] && !sync_sck[2];
  assign sck_fall = cs_low && !sync_sck[1] && sync_sck[2];
  assign xtal_ok  = sync_xtal[1];

  phase_t      phase;
  header_t     hdr;
  logic [2:0]  bit_cnt;
  logic [6:0]  shift_in;
  logic [7:0]  shift_out;
  logic [5:0]  addr;
  logic [7:0]  cfg [`CFG_COUNT];
  logic [7:0]  next_byte;
  logic        byte_done;
  logic        pend_power_down, pend_osc_off, pend_wake;
  logic        idle_block;
  logic [7:0]  settle_cnt;
  status_t     status;

  assign next_byte = {shift_in, sync_si[1]};
  assign byte_done = sck_rise && bit_cnt == 3'd7;

  function automatic logic [3:0] saturate(input logic [6:0] n);
    saturate = (n > 7'd15) ? `LEVEL_MAX : n[3:0];
  endfunction

  logic        is_strobe;
  logic        level_read;
  header_t     new_hdr;
  assign new_hdr   = header_t'(next_byte);
  assign is_strobe = !new_hdr.burst && new_hdr.addr >= `STROBE_FIRST
                     && new_hdr.addr <= `STROBE_LAST;
  // data bytes keep the direction of their header
  assign level_read = (phase == ph_header) ? new_hdr.read : hdr.read;

  always_comb
  begin
    status.not_ready = !xtal_ok;
    status.state     = radio_state;
    status.level     = level_read ? saturate(rx_fill)
                                  : saturate(tx_free);
  end

  // byte phase and address counter
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      phase    <= ph_header;
      bit_cnt  <= 3'd0;
      shift_in <= 7'h00;
      hdr      <= header_t'(8'h00);
      addr     <= 6'h00;
    end
    else if (!cs_low)
    begin
      phase   <= ph_header;
      bit_cnt <= 3'd0;
    end
    else if (sck_rise)
    begin
      bit_cnt  <= bit_cnt + 3'd1;
      shift_in <= next_byte[6:0];
      if (bit_cnt == 3'd7)
      begin
        if (phase == ph_header)
        begin
          hdr  <= new_hdr;
          addr <= new_hdr.addr;
          if (is_strobe)
            phase <= ph_header;
          else if (new_hdr.addr >= `STROBE_FIRST && new_hdr.burst)
            phase <= new_hdr.read ? ph_read : ph_skip;
          else if (new_hdr.addr <= `CFG_LAST_ADDR)
            phase <= new_hdr.read ? ph_read : ph_write;
          else
            phase <= ph_skip;
        end
        else if (hdr.burst && hdr.addr <= `CFG_LAST_ADDR)
          addr <= addr + 6'd1;
        else
          phase <= ph_header;
      end
    end
  end

  // configuration store
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < `CFG_COUNT; i++)
        cfg[i] <= `CFG_RESET_VALUE;
    end
    else if (byte_done && phase == ph_write && addr <= `CFG_LAST_ADDR)
      cfg[addr] <= next_byte;
  end

  function automatic logic [7:0] read_value(input logic [5:0] a);
    if (a <= `CFG_LAST_ADDR)
      read_value = cfg[a];
    else if (a == `ADDR_RADIO_STATE)
      read_value = {5'h00, radio_state};
    else if (a == `ADDR_TX_COUNT)
      read_value = {1'b0, tx_free};
    else if (a == `ADDR_RX_COUNT)
      read_value = {1'b0, rx_fill};
    else
      read_value = 8'h00;
  endfunction

  // output shifter: status on header and write bytes, data on reads
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_out             <= 8'h00;
      serial_out            <= 1'b1;
      serial_out_enable_low <= 1'b1;
    end
    else if (!cs_low)
    begin
      serial_out_enable_low <= 1'b1;
      serial_out            <= 1'b1;
    end
    else
    begin
      serial_out_enable_low <= 1'b0;
      if (byte_done)
      begin
        if (phase == ph_header && !is_strobe && new_hdr.read
            && (new_hdr.addr <= `CFG_LAST_ADDR || new_hdr.burst))
          shift_out <= read_value(new_hdr.addr);
        else if (phase == ph_read && hdr.burst
                 && hdr.addr <= `CFG_LAST_ADDR)
          shift_out <= read_value(addr + 6'd1);
        else
          shift_out <= status;
      end
      else if (sck_fall && bit_cnt != 3'd0)
      begin
        serial_out <= shift_out[7 - bit_cnt];
      end
      else if (phase == ph_header && bit_cnt == 3'd0 && sck_rise)
      begin
        // header bit 7 arrives first; level chosen once it is known
        shift_out[3:0] <= sync_si[1] ? saturate(rx_fill)
                                     : saturate(tx_free);
      end
      else if (bit_cnt == 3'd0 && !sync_sck[1])
      begin
        // wait for the falling edge so the host still sees bit 0
        // ready flag drives the line before the first rising edge of header and write bytes; data bit 7 on reads
        serial_out <= (phase == ph_header || phase == ph_write)
                      ? status.not_ready : shift_out[7];
        shift_out  <= (phase == ph_header || phase == ph_write)
                      ? status : shift_out;
      end
    end
  end

  // strobe execution and main state
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      radio_state     <= st_idle;
      strobe_code     <= 4'h0;
      strobe_pulse    <= 1'b0;
      pend_power_down <= 1'b0;
      pend_osc_off    <= 1'b0;
      pend_wake       <= 1'b0;
      idle_block      <= 1'b0;
      settle_cnt      <= 8'h00;
    end
    else
    begin
      strobe_pulse <= 1'b0;
      if (settle_cnt != 8'h00)
      begin
        settle_cnt <= settle_cnt - 8'h01;
        if (settle_cnt == 8'h01)
        begin
          radio_state <= (radio_state == st_settling) ? st_idle
                                                      : radio_state;
          idle_block  <= 1'b0;
        end
      end
      if (rx_overflow && radio_state == st_rx)
        radio_state <= st_rx_over;
      if (tx_underflow && radio_state == st_tx)
        radio_state <= st_tx_under;
      if (byte_done && phase == ph_header && is_strobe && !idle_block)
      begin
        strobe_code  <= 4'(new_hdr.addr - `STROBE_FIRST);
        unique case (new_hdr.addr)
          `STROBE_POWER_DOWN: pend_power_down <= 1'b1;
          `STROBE_OSC_OFF:    pend_osc_off    <= 1'b1;
          `STROBE_WAKE_RADIO: pend_wake       <= 1'b1;
          `STROBE_IDLE:
          begin
            strobe_pulse <= 1'b1;
            radio_state  <= st_settling;
            idle_block   <= 1'b1;
            settle_cnt   <= 8'(SETTLE);
          end
          `STROBE_RX:
          begin
            strobe_pulse <= 1'b1;
            radio_state  <= st_rx;
          end
          `STROBE_TX:
          begin
            strobe_pulse <= 1'b1;
            radio_state  <= st_tx;
          end
          `STROBE_FLUSH_RX, `STROBE_FLUSH_TX:
          begin
            strobe_pulse <= 1'b1;
            radio_state  <= st_idle;
          end
          default: strobe_pulse <= 1'b1;
        endcase
      end
      else if (cs_rise && (pend_power_down || pend_osc_off || pend_wake))
      begin
        strobe_pulse    <= 1'b1;
        strobe_code     <= pend_power_down ? 4'(`STROBE_POWER_DOWN - 6'h30)
                         : pend_osc_off ? 4'(`STROBE_OSC_OFF - 6'h30)
                         : 4'(`STROBE_WAKE_RADIO - 6'h30);
        pend_power_down <= 1'b0;
        pend_osc_off    <= 1'b0;
        pend_wake       <= 1'b0;
      end
    end
  end

  strobe_blocked_a: assert property (
    @(posedge clock) disable iff (!resetn)
    idle_block && byte_done && phase == ph_header && is_strobe
    |=> !strobe_pulse) else $error("strobe ran while idle pending");

  ready_flag_a: assert property (
    @(posedge clock) disable iff (!resetn)
    cs_low && phase == ph_header && bit_cnt == 3'd0 && !sync_sck[1]
    && !xtal_ok |=> serial_out) else $error("ready flag wrong");

  deferred_strobe_a: assert property (
    @(posedge clock) disable iff (!resetn)
    byte_done && phase == ph_header && new_hdr.addr == `STROBE_POWER_DOWN
    && !new_hdr.burst && !idle_block |=> !strobe_pulse && pend_power_down)
    else $error("power down not deferred");

  rx_strobe_a: assert property (
    @(posedge clock) disable iff (!resetn)
    byte_done && phase == ph_header && new_hdr.addr == `STROBE_RX
    && !new_hdr.burst && !idle_block |=> strobe_pulse
    && radio_state == st_rx) else $error("rx strobe not immediate");

  level_sat_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (!level_read && tx_free > 7'd15) |-> status.level == 4'hF)
    else $error("level not saturated");

  abandon_a: assert property (
    @(posedge clock) disable iff (!resetn)
    !cs_low |=> phase == ph_header && bit_cnt == 3'd0)
    else $error("transfer not abandoned");
endmodule // radio_spi_port
